// ===== hw/labce_pkg.sv
/*
 * shared constants and carrier types for the logic/bit-clear execute block.
 * assumes a core that hands over one 16-bit instruction word per cycle
 * and a data register file reached through a simple read/write port.
 */
// Operation
// [RQ1] literal AND into accumulator, zero flag only
// [RQ2] low byte is file address, one bit destination
// [RQ3] destination zero to accumulator, one to file
// [RQ4] register AND updates zero flag, one cycle
// [RQ5] bit clear zeroes one bit, flags untouched
// [RQ6] four phases: decode, read, execute, write
package labce_pkg;
    localparam int          DATA_W        = 8;
    localparam int          ADDR_W        = 8;
    localparam int          INSTR_W       = 16;
    localparam logic [7:0]  OP_ANDLIT     = 8'hB5;
    localparam logic [6:0]  OP_ANDFILE    = 7'h05;
    localparam logic [4:0]  OP_CLRBIT     = 5'h11;
    localparam int          DEST_BIT      = 8;
    localparam int          BITSEL_LSB    = 8;
    // accumulator comes up all ones: other core instructions load it, and
    // an all-zero start would pin every and result of this block at zero
    localparam logic [7:0]  ACC_RESET     = 8'hFF;
    localparam logic        DEST_ACC      = 1'b0;
    localparam logic        DEST_FILE     = 1'b1;

    typedef enum logic [3:0] {
        LABCE_Q1 = 4'b0001,
        LABCE_Q2 = 4'b0010,
        LABCE_Q3 = 4'b0100,
        LABCE_Q4 = 4'b1000
    } labce_phase_t;

    typedef enum logic [2:0] {
        LABCE_NONE = 3'b001,
        LABCE_ANDL = 3'b010,
        LABCE_ANDF = 3'b100
    } labce_unused_t;

    // one decoded instruction
    typedef struct packed {
        logic              isAndLit;
        logic              isAndFile;
        logic              isClrBit;
        logic              toFile;
        logic [2:0]        bitSel;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] literal;
    } labce_dec_t;

    // file register write request
    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } labce_fwr_t;
endpackage : labce_pkg

// ===== hw/labce_decoder.sv
/*
 * combinational opcode decoder for the three handled instructions.
 * assumes the instruction word is stable while it is decoded.
 */
`timescale 1ns/1ps
module labce_decoder (
    input  wire logic [15:0]        instr,
    output labce_pkg::labce_dec_t   dec
);
    // field extraction; other opcodes decode to no operation
    always_comb begin
        dec           = '0;
        dec.isAndLit  = (instr[15:8] == labce_pkg::OP_ANDLIT);  // see [RQ1]
        dec.isAndFile = (instr[15:9] == labce_pkg::OP_ANDFILE); // see [RQ4]
        dec.isClrBit  = (instr[15:11] == labce_pkg::OP_CLRBIT); // see [RQ5]
        dec.toFile    = instr[labce_pkg::DEST_BIT];            // see [RQ2]
        dec.bitSel    = instr[labce_pkg::BITSEL_LSB +: 3];
        dec.addr      = instr[7:0];                            // see [RQ2]
        dec.literal   = instr[7:0];
    end
endmodule : labce_decoder

// ===== hw/labce_exec.sv
/*
 * execute unit: and-literal, and-file and clear-bit over four phases.
 * assumes instrValid is held with instr until instrTaken pulses, and that
 * the register file returns fileRdData combinationally for fileRdAddr.
 */
`timescale 1ns/1ps
module labce_exec (
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    input  wire logic [15:0]           instr,
    input  wire logic                  instrValid,
    output logic                       instrTaken,
    output logic [7:0]                 fileRdAddr,
    input  wire logic [7:0]            fileRdData,
    output labce_pkg::labce_fwr_t      fileWr,
    output logic [7:0]                 workingAccumulator,
    output logic                       zeroFlag,
    output logic [3:0]                 phase
);
    labce_pkg::labce_dec_t  dec;
    labce_pkg::labce_dec_t  held;
    labce_pkg::labce_phase_t state;
    logic [7:0]             operand;
    logic [7:0]             result;
    logic                   active;

    ////////////////////////////////////////////////////////////////////////
    labce_decoder u_dec (
        .instr (instr),
        .dec   (dec)
    );

    function automatic logic [7:0] clr_mask(input logic [2:0] b);
        clr_mask = ~(8'h01 << b);
    endfunction : clr_mask

    ////////////////////////////////////////////////////////////////////////
    // phase sequencer, free running so timing matches the core cycle
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state <= labce_pkg::LABCE_Q1;
        end else begin
            unique case (state)                             // see [RQ6]
                labce_pkg::LABCE_Q1: state <= labce_pkg::LABCE_Q2;
                labce_pkg::LABCE_Q2: state <= labce_pkg::LABCE_Q3;
                labce_pkg::LABCE_Q3: state <= labce_pkg::LABCE_Q4;
                labce_pkg::LABCE_Q4: state <= labce_pkg::LABCE_Q1;
            endcase
        end
    end
    assign phase = state;

    // q1 decode: latch the instruction so late input changes do no harm
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            held   <= '0;
            active <= 1'b0;
        end else if (state == labce_pkg::LABCE_Q1) begin
            held   <= dec;                                  // see [RQ6]
            active <= instrValid;
        end
    end
    assign instrTaken = instrValid && (state == labce_pkg::LABCE_Q1);

    // q2 read literal or source register
    assign fileRdAddr = held.addr;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            operand <= 8'h00;
        end else if (state == labce_pkg::LABCE_Q2) begin
            operand <= held.isAndLit ? held.literal : fileRdData;
        end
    end

    // q3 execute
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            result <= 8'h00;
        end else if (state == labce_pkg::LABCE_Q3) begin
            if (held.isClrBit)
                result <= operand & clr_mask(held.bitSel);  // see [RQ5]
            else
                result <= workingAccumulator & operand;     // see [RQ1]
        end
    end

    // q4 accumulator and zero flag; bit clear leaves both alone
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            workingAccumulator <= labce_pkg::ACC_RESET;
            zeroFlag           <= 1'b0;
        end else if (state == labce_pkg::LABCE_Q4 && active) begin
            if (held.isAndLit || (held.isAndFile &&
                    held.toFile == labce_pkg::DEST_ACC))
                workingAccumulator <= result;               // see [RQ3]
            if (held.isAndLit || held.isAndFile)
                zeroFlag <= (result == 8'h00);              // see [RQ4]
        end
    end

    // q4 file write: registered so the strobe is clean for one cycle
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            fileWr <= '0;
        end else begin
            fileWr.we   <= (state == labce_pkg::LABCE_Q3) && active &&
                           (held.isClrBit || (held.isAndFile &&
                            held.toFile == labce_pkg::DEST_FILE)); // see [RQ3]
            fileWr.addr <= held.addr;
            fileWr.data <= (held.isClrBit)
                           ? (operand & clr_mask(held.bitSel))
                           : (workingAccumulator & operand);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks on the phase sequence and on what each instruction may touch;
    // all sample on the core clock and sleep while reset is high

    // a word taken in the first phase
    sequence seq_taken_q1;
        state == labce_pkg::LABCE_Q1 && instrValid;
    endsequence

    // the three phases that must follow it
    sequence seq_rest_of_cycle;
        state == labce_pkg::LABCE_Q2 ##1 state == labce_pkg::LABCE_Q3 ##1
        state == labce_pkg::LABCE_Q4;
    endsequence

    // a file strobe, then an accumulator left alone
    sequence seq_file_write;
        fileWr.we ##1 $stable(workingAccumulator);
    endsequence

    // phase discipline: writes only at the end, one word per four phases
    chk_write_in_q4: assert property ( // see [RQ6]
        @(posedge ref_clk) disable iff (reset)
        fileWr.we |-> state == labce_pkg::LABCE_Q4)
        else $error("file write outside final phase");

    chk_taken_phases: assert property ( // see [RQ6]
        @(posedge ref_clk) disable iff (reset)
        seq_taken_q1 |=> seq_rest_of_cycle ##1 state == labce_pkg::LABCE_Q1)
        else $error("taken word did not run four phases");

    chk_phase_cycle: assert property ( // see [RQ6]
        @(posedge ref_clk) disable iff (reset)
        state == labce_pkg::LABCE_Q1 |-> ##3 state == labce_pkg::LABCE_Q4)
        else $error("phase sequence broken");

    // literal and: operand is the low byte, no file traffic
    chk_lit_operand: assert property ( // see [RQ1]
        @(posedge ref_clk) disable iff (reset)
        (state == labce_pkg::LABCE_Q3 && active && held.isAndLit) |->
        operand == held.literal)
        else $error("literal not used as operand");

    chk_lit_no_write: assert property ( // see [RQ1]
        @(posedge ref_clk) disable iff (reset)
        (state == labce_pkg::LABCE_Q3 && active && held.isAndLit) |=>
        !fileWr.we)
        else $error("literal and wrote the file");

    chk_andl_zero: assert property ( // see [RQ1]
        @(posedge ref_clk) disable iff (reset)
        (state == labce_pkg::LABCE_Q4 && active && held.isAndLit) |=>
        zeroFlag == (workingAccumulator == 8'h00))
        else $error("zero flag mismatch after literal and");

    // register and: result, flag and destination
    chk_and_result: assert property ( // see [RQ4]
        @(posedge ref_clk) disable iff (reset)
        (state == labce_pkg::LABCE_Q4 && active &&
         (held.isAndLit || held.isAndFile)) |->
        result == (workingAccumulator & operand))
        else $error("and result differs from its operands");

    chk_andf_zero: assert property ( // see [RQ4]
        @(posedge ref_clk) disable iff (reset)
        (state == labce_pkg::LABCE_Q4 && active && held.isAndFile) |=>
        zeroFlag == (result == 8'h00))
        else $error("zero flag mismatch after file and");

    chk_andf_acc_load: assert property ( // see [RQ3]
        @(posedge ref_clk) disable iff (reset)
        (state == labce_pkg::LABCE_Q4 && active && held.isAndFile &&
         held.toFile == labce_pkg::DEST_ACC) |=>
        workingAccumulator == result)
        else $error("and to accumulator not loaded");

    chk_andf_dest_acc: assert property ( // see [RQ3]
        @(posedge ref_clk) disable iff (reset)
        (state == labce_pkg::LABCE_Q3 && active && held.isAndFile &&
         !held.toFile) |=> !fileWr.we)
        else $error("and to accumulator wrote the file");

    chk_andf_dest_file: assert property ( // see [RQ3]
        @(posedge ref_clk) disable iff (reset)
        (state == labce_pkg::LABCE_Q3 && active && held.isAndFile &&
         held.toFile) |=> seq_file_write)
        else $error("and to file missed write");

    chk_addr_kept: assert property ( // see [RQ2]
        @(posedge ref_clk) disable iff (reset)
        fileWr.we |-> fileWr.addr == fileRdAddr)
        else $error("write address differs from read address");

    // bit clear: one bit to zero, the rest and the flags untouched
    chk_clr_flags_kept: assert property ( // see [RQ5]
        @(posedge ref_clk) disable iff (reset)
        (state == labce_pkg::LABCE_Q4 && active && held.isClrBit) |=>
        $stable(zeroFlag) && $stable(workingAccumulator))
        else $error("bit clear changed flag or accumulator");

    chk_clr_bit_zero: assert property ( // see [RQ5]
        @(posedge ref_clk) disable iff (reset)
        (fileWr.we && held.isClrBit) |->
        fileWr.data[held.bitSel] == 1'b0)
        else $error("selected bit not cleared");

    chk_clr_others_kept: assert property ( // see [RQ5]
        @(posedge ref_clk) disable iff (reset)
        (fileWr.we && held.isClrBit) |->
        (fileWr.data | (8'h01 << held.bitSel)) ==
        (operand | (8'h01 << held.bitSel)))
        else $error("bit clear disturbed other bits");
endmodule : labce_exec

// ===== testbench/labce_regfile_model.sv
/*
 * behavioural data register file facing the execute block.
 * assumes one write port sampled on the rising clock edge.
 */
`timescale 1ns/1ps
module labce_regfile_model (
    input  wire logic                  ref_clk,
    input  wire logic [7:0]            fileRdAddr,
    output logic [7:0]                 fileRdData,
    input  wire labce_pkg::labce_fwr_t fileWr
);
    logic [7:0] mem [256];
    int         wrCount = 0;
    // every cell starts all ones so that cleared bits stand out
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
    end
    // read is combinational, as the execute block samples it late in Q2
    assign fileRdData = mem[fileRdAddr];
    // write port, counted so that stray writes are seen
    always @(posedge ref_clk) begin
        if (fileWr.we === 1'b1) begin
            mem[fileWr.addr] <= fileWr.data;
            wrCount <= wrCount + 1;
        end
    end
endmodule : labce_regfile_model

// ===== testbench/labce_exec_tb_top.sv
/*
 * self-checking bench for the execute block.
 * assumes the register file model and 40 MHz core clock.
 */
`timescale 1ns/1ps
module labce_exec_tb_top;
    logic                  ref_clk = 1'b0;
    logic                  reset = 1'b1;
    logic [15:0]           instr = 16'h0000;
    logic                  instrValid = 1'b0;
    logic                  instrTaken, zeroFlag;
    logic [7:0]            fileRdAddr, fileRdData, workingAccumulator;
    logic [3:0]            phase;
    labce_pkg::labce_fwr_t fileWr;
    int                    miscompares = 0;
    int                    checked = 0;
    int                    cycles = 0;
    labce_exec labce_exec_i (.ref_clk(ref_clk), .reset(reset), .instr(instr),
        .instrValid(instrValid), .instrTaken(instrTaken),
        .fileRdAddr(fileRdAddr), .fileRdData(fileRdData), .fileWr(fileWr),
        .workingAccumulator(workingAccumulator), .zeroFlag(zeroFlag),
        .phase(phase));
    labce_regfile_model labce_regfile_model_i (.ref_clk(ref_clk),
        .fileRdAddr(fileRdAddr), .fileRdData(fileRdData), .fileWr(fileWr));
    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard; the ceiling is well above the roughly 80 cycles used
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task complete_run();
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    task check8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check8
    // present one word in a Q1 cycle, return in the next Q1
    task run_instr(input logic [15:0] word);
        int n;
        n = 0;
        while (phase !== 4'b0001 && n < 8) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        instr = word;
        instrValid = 1'b1;
        #1 check8({7'h00, instrTaken}, 8'h01);
        @(posedge ref_clk);
        #1 instrValid = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask : run_instr
    ////////////////////////////////////////////////////////////////////////
    // every bit position of the top address; flags and accumulator stay put
    task test_clear_bits();
        logic [7:0] exp;
        exp = 8'hFF;
        for (int b = 0; b < 8; b++) begin
            run_instr({5'h11, b[2:0], 8'hFF});
            exp = exp & ~(8'h01 << b);
            check8(labce_regfile_model_i.mem[255], exp);
            check8({7'h00, zeroFlag}, 8'h00);
            check8(workingAccumulator, 8'hFF);
        end
    endtask : test_clear_bits
    // literal and twice: a non-zero then a zero result, no file traffic
    task test_and_literal();
        int w;
        w = labce_regfile_model_i.wrCount;
        run_instr(16'hB5A0);
        check8(workingAccumulator, 8'h20);
        check8({7'h00, zeroFlag}, 8'h00);
        run_instr(16'hB55F);
        check8(workingAccumulator, 8'h00);
        check8({7'h00, zeroFlag}, 8'h01);
        check8(8'(labce_regfile_model_i.wrCount - w), 8'h00);
    endtask : test_and_literal
    // both destinations while the accumulator is all ones, then an unknown
    task test_and_file();
        int w;
        run_instr(16'h8F00);
        check8(labce_regfile_model_i.mem[0], 8'h7F);
        w = labce_regfile_model_i.wrCount;
        run_instr(16'h0BFF);
        check8(labce_regfile_model_i.mem[255], 8'h00);
        check8(8'(labce_regfile_model_i.wrCount - w), 8'h01);
        check8(workingAccumulator, 8'hFF);
        check8({7'h00, zeroFlag}, 8'h01);
        run_instr(16'h0A00);
        check8(workingAccumulator, 8'h7F);
        check8({7'h00, zeroFlag}, 8'h00);
        check8(8'(labce_regfile_model_i.wrCount - w), 8'h01);
        run_instr(16'h0B01);
        check8(labce_regfile_model_i.mem[1], 8'h7F);
        check8(8'(labce_regfile_model_i.wrCount - w), 8'h02);
        check8(workingAccumulator, 8'h7F);
        run_instr(16'hFF01);
        check8(labce_regfile_model_i.mem[1], 8'h7F);
        check8(8'(labce_regfile_model_i.wrCount - w), 8'h02);
        check8(workingAccumulator, 8'h7F);
    endtask : test_and_file
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge ref_clk);
        #1 reset = 1'b0;
        test_clear_bits();
        test_and_file();
        test_and_literal();
        complete_run();
    end
endmodule : labce_exec_tb_top
